//--- hw/sbtc_timer.sv
/*
  One 16-bit timer half: one-shot, periodic, edge count, edge time and PWM.
  Assumes control bits are held by software as levels and writes come as one-cycle strobes;
  a debugger halt indication arrives synchronous to clk.
*/
`timescale 1ns/100ps
// Functional notes
// - Channel works only while the configuration value is 0x4.
// - One-shot and periodic count down 16 bits, extended by an 8-bit prescaler.
// - Mode field 0x1 selects one-shot, 0x2 selects periodic.
// - Enabled counter counts down; the cycle after zero it reloads load and prescale.
// - One-shot stops and clears enable at zero; periodic keeps counting.
// - Each zero sets the timeout flag, held until software clears it.
// - Unmasked timeout also sets the masked flag and raises an interrupt.
// - Timeout trigger to the converter only when its enable bit is set.
// - Writing the load value while running restarts the count from it next cycle.
// - With debug stall set, counting freezes while the processor is halted.
// - Edge count, edge time and PWM use the bare 16-bit counter.
// - Capture bit 0 counts rising, falling or both edges downward.
// - Each selected edge decrements by one; reaching match sets the match flags.
// - After match, reload from load value, clear enable, ignore edges until re-enabled.
// - Capture bit 1 runs a free down-counter from the load value, 0xFFFF at reset.
// - Each selected edge captures the count and sets the event flags.
// - Edge time keeps running until disabled and reloads at zero.
// - A captured count stays until the next selected edge replaces it.
// - PWM needs alternate select 1, capture bit 0 and mode field 0x2.
// - PWM counts down, reloads after zero, and raises no flags.
// - PWM goes active at the load value, inactive at match; invert bit flips it.
module sbtc_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [2:0] config_reg,
  input wire logic [1:0] timer_mode_field,
  input wire logic capture_mode_bit,
  input wire logic alternate_mode_select,
  input wire logic [1:0] edge_select,
  input wire logic adc_trigger_enable,
  input wire logic debug_stall_bit,
  input wire logic pwm_invert_bit,
  input wire logic debug_halt,
  input wire logic enable_set,
  input wire logic enable_clear,
  input wire logic load_write,
  input wire logic [15:0] load_data,
  input wire logic prescale_write,
  input wire logic [7:0] prescale_data,
  input wire logic [15:0] match_reg,
  input wire logic [2:0] interrupt_mask_reg,
  input wire logic [2:0] interrupt_clear_reg,
  input wire logic capture_compare_pin_in,
  output logic capture_compare_pin_out,
  output logic capture_compare_pin_oe,
  output logic count_enable_bit,
  output logic [15:0] timer_value_reg,
  output logic [15:0] interval_load_reg,
  output logic [7:0] prescale_reg,
  output logic [2:0] raw_status_reg,
  output logic [2:0] masked_status_reg,
  output logic timer_irq,
  output logic adc_trigger
);
  import sbtc_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0] pre;
    logic [15:0] load;
    logic [7:0] pre_load;
    logic [15:0] value;
    logic en;
    logic pwm_level;
    logic pwm_out;
    logic pwm_oe;
    logic adc;
  } sbtc_state_t;

  sbtc_state_t state;
  sbtc_state_t next_state;
  sbtc_op_t op;
  logic pin_rise;
  logic pin_fall;
  logic edge_hit;
  logic running;
  logic [15:0] count_dec;
  logic [SBTC_NUM_FLAGS-1:0] flag_set;

  function automatic sbtc_op_t decode_op(input logic [2:0] cfg, input logic [1:0] mode,
                                         input logic cmr, input logic ams);
    sbtc_op_t res;
    res = SBTC_OP_IDLE;
    if (cfg == SBTC_CFG_16BIT) begin
      if (ams && !cmr && mode == SBTC_MODE_PERIODIC) begin
        res = SBTC_OP_PWM;
      end else if (mode == SBTC_MODE_ONESHOT || mode == SBTC_MODE_PERIODIC) begin
        res = SBTC_OP_TIMER;
      end else if (mode == SBTC_MODE_CAPTURE) begin
        res = cmr ? SBTC_OP_TIME : SBTC_OP_COUNT;
      end
    end
    return res;
  endfunction

  function automatic logic edge_selected(input logic [1:0] sel, input logic r, input logic f);
    logic res;
    res = 1'b0;
    case (sel)
      SBTC_EDGE_RISE: res = r;
      SBTC_EDGE_FALL: res = f;
      SBTC_EDGE_BOTH: res = r | f;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  sbtc_edge_detect u_edge (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pin_in(capture_compare_pin_in),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign op = decode_op(config_reg, timer_mode_field, capture_mode_bit, alternate_mode_select);
  assign edge_hit = edge_selected(edge_select, pin_rise, pin_fall);
  // A halted processor freezes the count only when stall is requested
  assign running = state.en & ~(debug_stall_bit & debug_halt);
  assign count_dec = state.count - 16'h0001;

  always_comb begin
    next_state = state;
    next_state.adc = 1'b0;
    flag_set = '0;
    if (enable_set) begin
      next_state.en = 1'b1;
    end
    if (enable_clear) begin
      next_state.en = 1'b0;
    end
    if (prescale_write) begin
      next_state.pre_load = prescale_data;
    end
    if (load_write) begin
      next_state.load = load_data;
    end
    case (op)
      SBTC_OP_TIMER: begin
        if (running) begin
          if (state.count == SBTC_ZERO16 && state.pre == SBTC_ZERO8) begin
            // Zero state: reload both stages and time out
            next_state.count = state.load;
            next_state.pre = state.pre_load;
            flag_set[SBTC_FLAG_TIMEOUT] = 1'b1;
            next_state.adc = adc_trigger_enable;
            if (timer_mode_field == SBTC_MODE_ONESHOT) begin
              next_state.en = 1'b0;
            end
          end else if (state.pre == SBTC_ZERO8) begin
            // Prescaler wraps and steps the 16-bit count
            next_state.pre = state.pre_load;
            next_state.count = count_dec;
          end else begin
            next_state.pre = state.pre - 8'h01;
          end
        end
      end
      SBTC_OP_COUNT: begin
        // Disabled counter ignores edges
        if (running && edge_hit) begin
          next_state.count = count_dec;
          if (count_dec == match_reg) begin
            flag_set[SBTC_FLAG_MATCH] = 1'b1;
            next_state.count = state.load;
            next_state.en = 1'b0;
          end
        end
      end
      SBTC_OP_TIME: begin
        if (running) begin
          // Free running, reloads at zero until disabled
          next_state.count = (state.count == SBTC_ZERO16) ? state.load : count_dec;
          if (edge_hit) begin
            next_state.value = state.count;
            flag_set[SBTC_FLAG_EVENT] = 1'b1;
          end
        end
      end
      SBTC_OP_PWM: begin
        if (running) begin
          // Bare 16-bit counter, no flags
          next_state.count = (state.count == SBTC_ZERO16) ? state.load : count_dec;
          if (state.count == state.load) begin
            next_state.pwm_level = 1'b1;
          end else if (state.count == match_reg) begin
            next_state.pwm_level = 1'b0;
          end
        end
      end
      default: begin
      end
    endcase
    // A load write overrides the step, so counting resumes from the new value
    if (load_write) begin
      next_state.count = load_data;
      next_state.pre = next_state.pre_load;
    end
    // Prescaler stays parked outside the plain timer modes
    if (op != SBTC_OP_TIMER) begin
      next_state.pre = SBTC_ZERO8;
    end
    // Outside edge time the value register mirrors the live count
    if (op != SBTC_OP_TIME) begin
      next_state.value = next_state.count;
    end
    next_state.pwm_oe = (op == SBTC_OP_PWM);
    next_state.pwm_out = (op == SBTC_OP_PWM) & (next_state.pwm_level ^ pwm_invert_bit);
    if (op != SBTC_OP_PWM) begin
      next_state.pwm_level = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state.count <= SBTC_COUNT_RESET;
      state.pre <= SBTC_PRESCALE_RESET;
      state.load <= SBTC_LOAD_RESET;
      state.pre_load <= SBTC_PRESCALE_RESET;
      state.value <= SBTC_COUNT_RESET;
      state.en <= 1'b0;
      state.pwm_level <= 1'b0;
      state.pwm_out <= 1'b0;
      state.pwm_oe <= 1'b0;
      state.adc <= 1'b0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  sbtc_status_flags u_flags (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .set(flag_set),
    .clear(interrupt_clear_reg),
    .mask(interrupt_mask_reg),
    .raw(raw_status_reg),
    .masked(masked_status_reg),
    .irq(timer_irq)
  );

  assign capture_compare_pin_out = state.pwm_out;
  assign capture_compare_pin_oe = state.pwm_oe;
  assign count_enable_bit = state.en;
  assign timer_value_reg = state.value;
  assign interval_load_reg = state.load;
  assign prescale_reg = state.pre_load;
  assign adc_trigger = state.adc;
endmodule

//--- hw/sbtc_pkg.sv
/*
  Shared constants and types for the sixteen-bit timer channel.
  Assumes one system clock; every input is synchronous to it except the capture pin.
*/
package sbtc_pkg;
  // Configuration value that selects independent 16-bit halves
  localparam logic [2:0] SBTC_CFG_16BIT = 3'h4;
  // Timer mode field encodings
  localparam logic [1:0] SBTC_MODE_ONESHOT = 2'h1;
  localparam logic [1:0] SBTC_MODE_PERIODIC = 2'h2;
  localparam logic [1:0] SBTC_MODE_CAPTURE = 2'h3;
  // Edge select field encodings
  localparam logic [1:0] SBTC_EDGE_RISE = 2'h0;
  localparam logic [1:0] SBTC_EDGE_FALL = 2'h1;
  localparam logic [1:0] SBTC_EDGE_BOTH = 2'h3;
  // Reset values
  localparam logic [15:0] SBTC_LOAD_RESET = 16'hffff;
  localparam logic [15:0] SBTC_COUNT_RESET = 16'hffff;
  localparam logic [7:0] SBTC_PRESCALE_RESET = 8'h00;
  localparam logic [15:0] SBTC_ZERO16 = 16'h0000;
  localparam logic [7:0] SBTC_ZERO8 = 8'h00;
  // Status flag positions
  localparam int SBTC_FLAG_TIMEOUT = 0;
  localparam int SBTC_FLAG_MATCH = 1;
  localparam int SBTC_FLAG_EVENT = 2;
  localparam int SBTC_NUM_FLAGS = 3;
  // Decoded operating mode
  typedef enum logic [2:0] {
    SBTC_OP_IDLE,
    SBTC_OP_TIMER,
    SBTC_OP_COUNT,
    SBTC_OP_TIME,
    SBTC_OP_PWM
  } sbtc_op_t;
endpackage

//--- hw/sbtc_edge_detect.sv
/*
  Capture pin synchroniser and edge detector.
  Assumes the pin is asynchronous; edge pulses are one clock wide and qualified by ce.
*/
`timescale 1ns/100ps
module sbtc_edge_detect (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic pin_in,
  output logic rise,
  output logic fall
);
  import sbtc_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sbtc_sync_t;

  sbtc_sync_t state;
  sbtc_sync_t next_state;

  // Only the second stage reads the first one
  always_comb begin
    next_state = state;
    next_state.meta = pin_in;
    next_state.sync = state.meta;
    next_state.prev = state.sync;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Two cycles of stable level after an edge are assumed, so no edge is missed
  assign rise = ce & state.sync & ~state.prev;
  assign fall = ce & ~state.sync & state.prev;
endmodule

//--- hw/sbtc_status_flags.sv
/*
  Sticky raw status flags with mask and a combined interrupt request.
  Assumes set and clear are one-cycle pulses; a set in the clearing cycle wins.
*/
`timescale 1ns/100ps
module sbtc_status_flags (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [sbtc_pkg::SBTC_NUM_FLAGS-1:0] set,
  input wire logic [sbtc_pkg::SBTC_NUM_FLAGS-1:0] clear,
  input wire logic [sbtc_pkg::SBTC_NUM_FLAGS-1:0] mask,
  output logic [sbtc_pkg::SBTC_NUM_FLAGS-1:0] raw,
  output logic [sbtc_pkg::SBTC_NUM_FLAGS-1:0] masked,
  output logic irq
);
  import sbtc_pkg::*;

  typedef struct packed {
    logic [SBTC_NUM_FLAGS-1:0] raw;
    logic [SBTC_NUM_FLAGS-1:0] masked;
    logic irq;
  } sbtc_flag_t;

  sbtc_flag_t state;
  sbtc_flag_t next_state;
  logic [SBTC_NUM_FLAGS-1:0] next_raw;

  genvar i;
  generate
    for (i = 0; i < SBTC_NUM_FLAGS; i++) begin : g_flag
      // Held until cleared; new event beats the clear
      assign next_raw[i] = set[i] | (state.raw[i] & ~clear[i]);
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_state.raw = next_raw;
    next_state.masked = next_raw & mask;
    next_state.irq = |(next_raw & mask);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign raw = state.raw;
  assign masked = state.masked;
  assign irq = state.irq;
endmodule

//--- sim/sbtc_timer_properties.sv
/* Concurrent checks on the timer channel ports.
   Assumes binding to sbtc_timer, one clock, srst synchronous. */
`timescale 1ns/100ps
module sbtc_timer_properties import sbtc_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [2:0] config_reg,
  input wire logic [1:0] timer_mode_field,
  input wire logic capture_mode_bit,
  input wire logic alternate_mode_select,
  input wire logic debug_stall_bit,
  input wire logic debug_halt,
  input wire logic adc_trigger_enable,
  input wire logic enable_set,
  input wire logic enable_clear,
  input wire logic load_write,
  input wire logic [15:0] load_data,
  input wire logic [7:0] prescale_reg,
  input wire logic [2:0] interrupt_mask_reg,
  input wire logic [2:0] interrupt_clear_reg,
  input wire logic count_enable_bit,
  input wire logic [15:0] timer_value_reg,
  input wire logic [15:0] interval_load_reg,
  input wire logic [2:0] raw_status_reg,
  input wire logic [2:0] masked_status_reg,
  input wire logic adc_trigger
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic quiet;
  assign quiet = ce && !enable_set && !enable_clear && !load_write;
  // Prescale held at zero so that a zero count is the zero state
  sequence s_zero(m);
    quiet && config_reg == SBTC_CFG_16BIT && timer_mode_field == m && !alternate_mode_select
    && count_enable_bit && timer_value_reg == 16'h0000 && prescale_reg == 8'h00
    && !(debug_stall_bit && debug_halt);
  endsequence
  sequence s_reload;
    timer_value_reg == interval_load_reg && raw_status_reg[0];
  endsequence
  sequence s_pwm;
    config_reg == SBTC_CFG_16BIT && timer_mode_field == SBTC_MODE_PERIODIC
    && alternate_mode_select && !capture_mode_bit;
  endsequence
  oneshot_stop_a:
  assert property (s_zero(SBTC_MODE_ONESHOT) |=> s_reload ##0 !count_enable_bit)
    else $error("one-shot zero did not reload and stop");
  periodic_run_a:
  assert property (s_zero(SBTC_MODE_PERIODIC) |=> s_reload ##0 count_enable_bit)
    else $error("periodic zero did not reload and go on");
  flag_hold_a:
  assert property (ce && raw_status_reg[0] && !interrupt_clear_reg[0] |=> raw_status_reg[0])
    else $error("timeout flag dropped without clear");
  mask_gate_a:
  assert property (ce |=> masked_status_reg == (raw_status_reg & $past(interrupt_mask_reg)))
    else $error("masked flags differ from raw and mask");
  adc_gate_a:
  assert property (adc_trigger |-> $past(adc_trigger_enable) && raw_status_reg[0])
    else $error("trigger without enable or timeout");
  load_take_a:
  assert property (ce && load_write && !capture_mode_bit |=>
    interval_load_reg == $past(load_data) && timer_value_reg == $past(load_data))
    else $error("load write not taken next cycle");
  count_ignore_a:
  assert property (quiet && config_reg == SBTC_CFG_16BIT && !capture_mode_bit
    && timer_mode_field == SBTC_MODE_CAPTURE && !count_enable_bit |=> $stable(timer_value_reg))
    else $error("disabled edge counter moved");
  pwm_quiet_a:
  assert property (s_pwm ##0 raw_status_reg == 3'h0 ##1 s_pwm |-> raw_status_reg == 3'h0)
    else $error("flag raised in pwm mode");
endmodule
bind sbtc_timer sbtc_timer_properties chk_u (.clk(clk), .srst(srst), .ce(ce),
  .config_reg(config_reg), .timer_mode_field(timer_mode_field),
  .capture_mode_bit(capture_mode_bit), .alternate_mode_select(alternate_mode_select),
  .debug_stall_bit(debug_stall_bit), .debug_halt(debug_halt),
  .adc_trigger_enable(adc_trigger_enable), .enable_set(enable_set),
  .enable_clear(enable_clear), .load_write(load_write), .load_data(load_data),
  .prescale_reg(prescale_reg), .interrupt_mask_reg(interrupt_mask_reg),
  .interrupt_clear_reg(interrupt_clear_reg), .count_enable_bit(count_enable_bit),
  .timer_value_reg(timer_value_reg), .interval_load_reg(interval_load_reg),
  .raw_status_reg(raw_status_reg), .masked_status_reg(masked_status_reg),
  .adc_trigger(adc_trigger));

//--- sim/sbtc_pin_source.sv
/* Signal source on the capture pin.
   Assumes the bench calls toggle; the pin idles low from time zero. */
`timescale 1ns/100ps
module sbtc_pin_source (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;
  // Each level held three clocks, above the two-clock minimum
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      pin = ~pin;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

//--- sim/sbtc_timer_tb.sv
/* Self-checking bench for sbtc_timer.
   Assumes the pin source model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
module sbtc_timer_tb;
  import sbtc_pkg::*;
  typedef struct {string nm; logic [3:0] c; logic [15:0] e;} sbtc_note_t;
  logic clk = 0, srst = 1, ce = 1, en_set = 0, en_clr = 0, ld_wr = 0, ps_wr = 0;
  logic cmr = 0, ams = 0, adc_en = 1, stall = 0, inv = 0, halt = 0;
  logic pin, pout, poe, en, irq, adc;
  logic [2:0] cfg = 3'h4, mask = 3'h0, iclr = 3'h0, raw, msk;
  logic [1:0] mode = 2'h0, esel = 2'h0;
  logic [15:0] ld = 16'h0000, match = 16'h0000, tval, lval, meas, l;
  logic [7:0] ps = 8'h00, pval;
  int n_mismatch = 0, checks_done = 0, adc_n = 0, k;
  sbtc_note_t note_q[$];
  always #4 clk = ~clk;
  sbtc_pin_source src_u (.clk(clk), .pin(pin));
  sbtc_timer dut_u (.clk(clk), .srst(srst), .ce(ce), .config_reg(cfg),
    .timer_mode_field(mode), .capture_mode_bit(cmr), .alternate_mode_select(ams),
    .edge_select(esel), .adc_trigger_enable(adc_en), .debug_stall_bit(stall),
    .pwm_invert_bit(inv), .debug_halt(halt), .enable_set(en_set), .enable_clear(en_clr),
    .load_write(ld_wr), .load_data(ld), .prescale_write(ps_wr), .prescale_data(ps),
    .match_reg(match), .interrupt_mask_reg(mask), .interrupt_clear_reg(iclr),
    .capture_compare_pin_in(pin), .capture_compare_pin_out(pout),
    .capture_compare_pin_oe(poe), .count_enable_bit(en), .timer_value_reg(tval),
    .interval_load_reg(lval), .prescale_reg(pval), .raw_status_reg(raw),
    .masked_status_reg(msk), .timer_irq(irq), .adc_trigger(adc));
  function automatic logic [15:0] obs(input logic [3:0] c);
    case (c)
      4'h0: obs = tval;
      4'h2: obs = {8'h00, pval};
      4'h3: obs = {13'h0000, raw};
      4'h4: obs = {15'h0000, en};
      4'h5: obs = {15'h0000, irq};
      4'h6: obs = meas;
      4'h8: obs = adc_n[15:0];
      default: obs = {15'h0000, poe};
    endcase
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic note(input string nm, input logic [3:0] c, input logic [15:0] e);
    note_q.push_back('{nm, c, e});
  endtask
  // Every queued expectation is compared, oldest first, once outputs have settled
  always @(negedge clk) begin
    while (note_q.size() > 0) begin
      check(note_q[0].nm, obs(note_q[0].c), note_q[0].e);
      void'(note_q.pop_front());
    end
  end
  always @(posedge clk) begin
    if (adc === 1'b1) adc_n++;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Stop, clear flags and load in one cycle, enable in the next
  task automatic start_mode(input logic [1:0] m, input logic c, input logic a, input logic [15:0] v);
    mode = m;
    cmr = c;
    ams = a;
    iclr = 3'h7;
    en_clr = 1;
    ld = v;
    ld_wr = 1;
    step(1);
    iclr = 3'h0;
    en_clr = 0;
    ld_wr = 0;
    en_set = 1;
    step(1);
    en_set = 0;
  endtask
  task automatic wait_raw(input int b);
    k = 0;
    while (raw[b] !== 1'b1 && k < 300) begin
      step(1);
      k++;
    end
    meas = k[15:0];
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #160000;
    n_mismatch++;
    final_report();
  end
  initial begin
    void'($urandom(92));
    step(8);
    srst = 0;
    note("value", 0, SBTC_COUNT_RESET);
    note("prescale", 2, 16'h0000);
    cfg = 3'h0;
    start_mode(SBTC_MODE_PERIODIC, 1'b0, 1'b0, 16'h0005);
    step(10);
    note("idle", 0, 16'h0005);
    cfg = SBTC_CFG_16BIT;
    l = 16'h0003 + 16'($urandom % 8);
    mask = 3'h1;
    start_mode(SBTC_MODE_ONESHOT, 1'b0, 1'b0, l);
    wait_raw(0);
    step(1);
    note("period", 6, l + 16'h0001);
    note("enable", 4, 16'h0000);
    note("reload", 0, l);
    note("irq", 5, 16'h0001);
    note("adc", 8, 16'h0001);
    mask = 3'h0;
    adc_en = 0;
    start_mode(SBTC_MODE_PERIODIC, 1'b0, 1'b0, 16'h0004);
    wait_raw(0);
    step(1);
    note("run", 4, 16'h0001);
    note("adc_off", 8, 16'h0001);
    // Clock enable low must freeze the count mid-period
    ce = 0;
    step(12);
    note("frozen", 0, 16'h0003);
    ce = 1;
    stall = 1;
    halt = 1;
    iclr = 3'h1;
    step(1);
    iclr = 3'h0;
    step(20);
    note("halted", 3, 16'h0000);
    halt = 0;
    step(8);
    note("resumed", 3, 16'h0001);
    stall = 0;
    match = 16'h0007;
    // Last pass uses the spare select code, which must count no edge at all
    for (int i = 0; i < 4; i++) begin
      esel = (i == 2) ? SBTC_EDGE_BOTH : (i == 3) ? 2'h2 : 2'(i);
      start_mode(SBTC_MODE_CAPTURE, 1'b0, 1'b0, 16'h000a);
      src_u.toggle(5);
      step(4);
      note("edge_flag", 3, (i == 0 || i == 2) ? 16'h0002 : 16'h0000);
      note("edge_count", 0, (i == 1) ? 16'h0008 : 16'h000a);
      src_u.toggle(1);
      step(4);
    end
    esel = SBTC_EDGE_RISE;
    mask = 3'h4;
    start_mode(SBTC_MODE_CAPTURE, 1'b1, 1'b0, 16'h0100);
    step(20);
    src_u.toggle(1);
    repeat (2) begin
      step(10);
      meas = {15'h0000, tval <= 16'h00f0 && tval >= 16'h00e2};
      note("capture", 6, 16'h0001);
    end
    note("event_irq", 5, 16'h0001);
    ps = 8'h03;
    ps_wr = 1;
    step(1);
    ps_wr = 0;
    note("prescale_set", 2, 16'h0003);
    adc_en = 1;
    start_mode(SBTC_MODE_PERIODIC, 1'b0, 1'b0, 16'h0002);
    repeat (2) begin
      step(1);
      k = 1;
      while (adc !== 1'b1 && k < 100) begin
        step(1);
        k++;
      end
    end
    meas = k[15:0];
    note("scaled", 6, 16'h000c);
    match = 16'h0002;
    for (int i = 0; i < 2; i++) begin
      inv = i[0];
      start_mode(SBTC_MODE_PERIODIC, 1'b0, 1'b1, 16'h0009);
      step(12);
      k = 0;
      repeat (20) begin
        step(1);
        if (pout === 1'b1) k++;
      end
      meas = k[15:0];
      note("pwm_high", 6, (i == 1) ? 16'h0006 : 16'h000e);
      note("pwm_flags", 3, 16'h0000);
      note("pwm_drive", 9, 16'h0001);
    end
    // Reset in mid-run, with the PWM output still driving
    srst = 1;
    step(1);
    srst = 0;
    note("rst_value", 0, SBTC_COUNT_RESET);
    note("rst_drive", 9, 16'h0000);
    note("rst_enable", 4, 16'h0000);
    step(2);
    final_report();
  end
endmodule
